// ---- src/scm_pkg.sv ----
// scm_pkg: constants, enums and carriers of the two-wire serial master.
// assumes a 100 MHz system clock; quarter-bit counts derive from it.
package scm_pkg;

	localparam int SCM_CLK_PS = 10000;

	// selectable bus rates in kHz
	localparam int SCM_RATE0_KHZ = 100;
	localparam int SCM_RATE1_KHZ = 400;
	localparam int SCM_RATE2_KHZ = 800;
	localparam int SCM_RATE3_KHZ = 1000;

	// quarter bit time in ps, rounded up to cycles so no rate is exceeded
	localparam int SCM_QTR0_PS = 1000000000 / (4 * SCM_RATE0_KHZ);
	localparam int SCM_QTR1_PS = 1000000000 / (4 * SCM_RATE1_KHZ);
	localparam int SCM_QTR2_PS = 1000000000 / (4 * SCM_RATE2_KHZ);
	localparam int SCM_QTR3_PS = 1000000000 / (4 * SCM_RATE3_KHZ);
	localparam logic [9:0] SCM_QTR0_CYC =
		10'((SCM_QTR0_PS + SCM_CLK_PS - 1) / SCM_CLK_PS);
	localparam logic [9:0] SCM_QTR1_CYC =
		10'((SCM_QTR1_PS + SCM_CLK_PS - 1) / SCM_CLK_PS);
	localparam logic [9:0] SCM_QTR2_CYC =
		10'((SCM_QTR2_PS + SCM_CLK_PS - 1) / SCM_CLK_PS);
	localparam logic [9:0] SCM_QTR3_CYC =
		10'((SCM_QTR3_PS + SCM_CLK_PS - 1) / SCM_CLK_PS);

	localparam int SCM_MAX_BYTES = 16;
	localparam logic [3:0] SCM_ACK_BIT = 4'h8;
	localparam logic [1:0] SCM_PH_LAST = 2'h3;
	localparam logic [7:0] SCM_BYTE_RST = 8'h00;
	localparam logic [9:0] SCM_QCNT_RST = 10'h000;

	typedef enum logic [1:0] {
		SCM_MODE_READ = 2'b00,
		SCM_MODE_WRITE = 2'b01,
		SCM_MODE_RD_WR = 2'b10,
		SCM_MODE_WR_RD = 2'b11
	} scm_mode_type;

	typedef enum logic [1:0] {
		SCM_RATE_100K = 2'b00,
		SCM_RATE_400K = 2'b01,
		SCM_RATE_800K = 2'b10,
		SCM_RATE_1M = 2'b11
	} scm_rate_type;

	typedef enum logic [2:0] {
		SCM_ST_IDLE = 3'b000,
		SCM_ST_WAIT = 3'b001,
		SCM_ST_START = 3'b010,
		SCM_ST_BIT = 3'b011,
		SCM_ST_STOP = 3'b100
	} scm_state_type;

	// lengths hold count minus one: 0 means 1 byte, 15 means 16
	typedef struct packed {
		scm_mode_type mode;
		scm_rate_type rate;
		logic [6:0] addr;
		logic [3:0] len_a;
		logic [3:0] len_b;
	} scm_cmd_type;

	typedef struct packed {
		logic busy;
		logic done;
		logic nack;
	} scm_stat_type;

endpackage

// ---- src/scm_master.sv ----
// scm_master: two-wire serial bus master with 16-byte write and read
// buffers, driven by a command port from the local processor.
// assumes external pull-ups on both lines and a single master on the bus.
//
// Behaviour
// R1: The block is bus master only and runs read, write, read-then-write and write-then-read transfers.
// R2: No arbitration exists, so no other master may sit on the bus.
// R3: Clock stretching is not honoured, so slaves must keep pace with the clock.
// R4: Rates of 100 kHz and 400 kHz are selectable.
// R5: Rates of 800 kHz and 1 MHz are selectable as well.
// R6: A read fetches one to sixteen bytes.
// R7: A write sends one to sixteen bytes.
// R8: Read-then-write reads up to sixteen bytes, then writes up to sixteen.
// R9: Write-then-read writes up to sixteen bytes, then reads up to sixteen.
// R10: Once started, hardware sequences the whole transfer alone.
// R11: Both lines are open drain, only ever pulled low.
// R12: Combined transfers use a repeated start and fresh address, every transfer ends in a stop, and a missing acknowledge is reported.
`timescale 1ns/1ps
`default_nettype none

module scm_master
	import scm_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire scm_cmd_type cmd,
	output logic cmd_ready,
	input wire logic tx_we,
	input wire logic [3:0] tx_sel,
	input wire logic [7:0] tx_byte,
	input wire logic [3:0] rx_sel,
	output logic [7:0] rx_byte,
	output scm_stat_type stat,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);

	logic rst_meta_q, rst_s_q;
	logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
	logic [7:0] tx_mem_q [SCM_MAX_BYTES], tx_mem_d [SCM_MAX_BYTES];
	logic [7:0] rx_mem_q [SCM_MAX_BYTES], rx_mem_d [SCM_MAX_BYTES];
	logic [7:0] rx_byte_q, rx_byte_d, shreg_q, shreg_d, addr_byte;
	scm_state_type st_q, st_d;
	scm_cmd_type cmd_q, cmd_d;
	logic [1:0] ph_q, ph_d;
	logic [9:0] qcnt_q, qcnt_d, qtr;
	logic [3:0] bit_q, bit_d, byte_q, byte_d, len_cur;
	logic [3:0] tx_idx_q, tx_idx_d, rx_idx_q, rx_idx_d;
	logic sec_q, sec_d, addr_ph_q, addr_ph_d, nack_q, nack_d;
	logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d, done_q, done_d;
	logic rx_wr, tick, wr_dir, tx_mode, combined, last;

	// reset release through two flops; ce frozen also holds reset release
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_s_q <= 1'b0;
		end else if (ce) begin
			rst_meta_q <= 1'b1;
			rst_s_q <= rst_meta_q;
		end
	end

	// pin inputs pass two flops before use
	always_ff @(posedge clock or negedge rst_s_q) begin
		if (!rst_s_q) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else if (ce) begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
		end
	end

	// R4: rate select
	// R5: rate select
	always_comb begin
		case (cmd_q.rate)
			SCM_RATE_100K: qtr = SCM_QTR0_CYC;
			SCM_RATE_400K: qtr = SCM_QTR1_CYC;
			SCM_RATE_800K: qtr = SCM_QTR2_CYC;
			SCM_RATE_1M: qtr = SCM_QTR3_CYC;
			default: qtr = SCM_QTR0_CYC;
		endcase
	end

	// R1: direction per phase
	// R8: read first, then write
	// R9: write first, then read
	assign combined = (cmd_q.mode == SCM_MODE_RD_WR) ||
		(cmd_q.mode == SCM_MODE_WR_RD);
	assign wr_dir = sec_q ? (cmd_q.mode == SCM_MODE_RD_WR) :
		((cmd_q.mode == SCM_MODE_WRITE) || (cmd_q.mode == SCM_MODE_WR_RD));
	assign len_cur = sec_q ? cmd_q.len_b : cmd_q.len_a;
	assign tx_mode = addr_ph_q || wr_dir;
	assign last = !addr_ph_q && (byte_q == len_cur);
	// R12: address resent with new direction
	assign addr_byte = {cmd_q.addr, !wr_dir};
	assign tick = (qcnt_q == SCM_QCNT_RST);

	// buffers: software fills tx only while idle
	always_comb begin
		tx_mem_d = tx_mem_q;
		rx_mem_d = rx_mem_q;
		if (tx_we && st_q == SCM_ST_IDLE) begin
			tx_mem_d[tx_sel] = tx_byte;
		end
		// R6: read byte stored
		if (rx_wr) begin
			rx_mem_d[rx_idx_q] = shreg_q;
		end
		rx_byte_d = rx_mem_q[rx_sel];
	end

	always_ff @(posedge clock or negedge rst_s_q) begin
		if (!rst_s_q) begin
			for (int i = 0; i < SCM_MAX_BYTES; i++) begin
				tx_mem_q[i] <= SCM_BYTE_RST;
				rx_mem_q[i] <= SCM_BYTE_RST;
			end
			rx_byte_q <= SCM_BYTE_RST;
		end else if (ce) begin
			tx_mem_q <= tx_mem_d;
			rx_mem_q <= rx_mem_d;
			rx_byte_q <= rx_byte_d;
		end
	end

	// bus sequencer, four quarter phases per bit
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		ph_d = ph_q;
		qcnt_d = qcnt_q;
		bit_d = bit_q;
		byte_d = byte_q;
		tx_idx_d = tx_idx_q;
		rx_idx_d = rx_idx_q;
		shreg_d = shreg_q;
		sec_d = sec_q;
		addr_ph_d = addr_ph_q;
		scl_oe_d = scl_oe_q;
		sda_oe_d = sda_oe_q;
		nack_d = nack_q;
		done_d = 1'b0;
		rx_wr = 1'b0;
		if (st_q != SCM_ST_IDLE && st_q != SCM_ST_WAIT) begin
			qcnt_d = tick ? qtr - 10'h001 : qcnt_q - 10'h001;
		end
		case (st_q)
			SCM_ST_IDLE: begin
				// R10: one command runs the whole transfer
				if (cmd_valid) begin
					cmd_d = cmd;
					nack_d = 1'b0;
					sec_d = 1'b0;
					tx_idx_d = 4'h0;
					rx_idx_d = 4'h0;
					st_d = SCM_ST_WAIT;
				end
			end
			SCM_ST_WAIT: begin
				// R2: start only on an idle bus, no arbitration after
				if (scl_s_q && sda_s_q) begin
					st_d = SCM_ST_START;
					ph_d = 2'h0;
					qcnt_d = qtr - 10'h001;
				end
			end
			SCM_ST_START: begin
				if (tick) begin
					ph_d = ph_q + 2'h1;
					case (ph_q)
						2'h0: scl_oe_d = 1'b0;
						2'h1: sda_oe_d = 1'b1;
						2'h2: scl_oe_d = 1'b1;
						default: begin
							shreg_d = addr_byte;
							sda_oe_d = !addr_byte[7];
							addr_ph_d = 1'b1;
							bit_d = 4'h0;
							byte_d = 4'h0;
							st_d = SCM_ST_BIT;
						end
					endcase
				end
			end
			SCM_ST_BIT: begin
				if (tick) begin
					ph_d = ph_q + 2'h1;
					case (ph_q)
						// R3: clock released, never checked for stretch
						2'h0: scl_oe_d = 1'b0;
						2'h1: scl_oe_d = 1'b0;
						2'h2: begin
							scl_oe_d = 1'b1;
							if (bit_q == SCM_ACK_BIT) begin
								// R12: missing acknowledge caught
								if (tx_mode && sda_s_q) begin
									nack_d = 1'b1;
								end
							end else if (!tx_mode) begin
								shreg_d = {shreg_q[6:0], sda_s_q};
							end
						end
						default: begin
							if (bit_q != SCM_ACK_BIT) begin
								bit_d = bit_q + 4'h1;
								if (tx_mode) begin
									shreg_d = {shreg_q[6:0], 1'b0};
								end
								// master acks all read bytes but the last
								if (bit_d == SCM_ACK_BIT) begin
									sda_oe_d = !tx_mode && !last;
								end else begin
									sda_oe_d = tx_mode && !shreg_d[7];
								end
							end else if (tx_mode && nack_q) begin
								// R12: refused byte ends the transfer
								st_d = SCM_ST_STOP;
								sda_oe_d = 1'b1;
							end else begin
								bit_d = 4'h0;
								if (!tx_mode) begin
									rx_wr = 1'b1;
									rx_idx_d = rx_idx_q + 4'h1;
								end
								if (!addr_ph_q && last) begin
									if (combined && !sec_q) begin
										// R12: repeated start between phases
										sec_d = 1'b1;
										st_d = SCM_ST_START;
										sda_oe_d = 1'b0;
									end else begin
										st_d = SCM_ST_STOP;
										sda_oe_d = 1'b1;
									end
								end else begin
									// R6: up to sixteen read bytes
									// R7: up to sixteen written bytes
									byte_d = addr_ph_q ? 4'h0 : byte_q + 4'h1;
									addr_ph_d = 1'b0;
									if (wr_dir) begin
										shreg_d = tx_mem_q[tx_idx_q];
										tx_idx_d = tx_idx_q + 4'h1;
										sda_oe_d = !shreg_d[7];
									end else begin
										sda_oe_d = 1'b0;
									end
								end
							end
						end
					endcase
				end
			end
			SCM_ST_STOP: begin
				if (tick) begin
					ph_d = ph_q + 2'h1;
					case (ph_q)
						2'h0: scl_oe_d = 1'b0;
						// R12: stop ends every transfer
						2'h1: sda_oe_d = 1'b0;
						2'h2: sda_oe_d = 1'b0;
						default: begin
							done_d = 1'b1;
							st_d = SCM_ST_IDLE;
						end
					endcase
				end
			end
			default: begin
				st_d = SCM_ST_IDLE;
				scl_oe_d = 1'b0;
				sda_oe_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_s_q) begin
		if (!rst_s_q) begin
			st_q <= SCM_ST_IDLE;
			cmd_q <= '0;
			ph_q <= 2'h0;
			qcnt_q <= SCM_QCNT_RST;
			bit_q <= 4'h0;
			byte_q <= 4'h0;
			tx_idx_q <= 4'h0;
			rx_idx_q <= 4'h0;
			shreg_q <= SCM_BYTE_RST;
			sec_q <= 1'b0;
			addr_ph_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			nack_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			ph_q <= ph_d;
			qcnt_q <= qcnt_d;
			bit_q <= bit_d;
			byte_q <= byte_d;
			tx_idx_q <= tx_idx_d;
			rx_idx_q <= rx_idx_d;
			shreg_q <= shreg_d;
			sec_q <= sec_d;
			addr_ph_q <= addr_ph_d;
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
			nack_q <= nack_d;
			done_q <= done_d;
		end
	end

	// R11: open drain, output level fixed low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;
	assign cmd_ready = (st_q == SCM_ST_IDLE);
	assign rx_byte = rx_byte_q;
	assign stat = {(st_q != SCM_ST_IDLE), done_q, nack_q};

endmodule

`default_nettype wire

// ---- verification/scm_master_monitor.sv ----
// scm_master_monitor: port checks on the two-wire master.
// assumes one clock domain; bound onto every scm_master.
`timescale 1ns/1ps
`default_nettype none
module scm_master_monitor
	import scm_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire scm_stat_type stat,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic scl_o,
	input wire logic sda_o
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence take_s; ce && cmd_valid && cmd_ready; endsequence
	sequence start_s; $rose(sda_oe) && !scl_oe; endsequence
	sequence stop_s; $fell(sda_oe) && !scl_oe; endsequence
	sequence frozen_s; $stable({scl_oe, sda_oe, stat}); endsequence
	chk_ready_vs_busy: assert property (cmd_ready == !stat.busy)
		else $error("ready and busy disagree");
	chk_take_busy: assert property (take_s |=> stat.busy)
		else $error("command not taken");
	chk_take_nack_clr: assert property (take_s |=> !stat.nack)
		else $error("nack kept");
	chk_done_pulse: assert property (stat.done && ce |=> !stat.done)
		else $error("done too long");
	chk_busy_end_done: assert property ($fell(stat.busy) |-> stat.done)
		else $error("busy ended without done");
	chk_idle_released: assert property (cmd_ready |-> !scl_oe && !sda_oe)
		else $error("line held while idle");
	chk_start_clock: assert property (start_s |-> ##[1:260] scl_oe)
		else $error("start without clock");
	chk_stop_done: assert property (stop_s |-> ##[1:600] stat.done)
		else $error("stop without done");
	chk_drive_low: assert property (!scl_o && !sda_o)
		else $error("pin level not low");
	chk_ce_freeze: assert property (!ce |=> frozen_s)
		else $error("state moved while frozen");
endmodule
bind scm_master scm_master_monitor mon (.clock, .rst_n, .ce, .cmd_valid,
	.cmd_ready, .stat, .scl_oe, .sda_oe, .scl_o, .sda_o);
`default_nettype wire

// ---- verification/scm_slave_model.sv ----
// scm_slave_model: behavioural two-wire slave, 16-byte memory.
// assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module scm_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe
);
	logic [7:0] mem [16];
	logic [7:0] sh;
	logic [3:0] idx;
	logic rd, act, first;
	int bc;
	initial begin
		{sda_oe, rd, act, first, idx} = '0;
		bc = 0;
	end
	// clock never touched, data only pulled low
	always @(negedge sda) if (scl) begin
		bc = 0;
		first = 1'h1;
	end
	always @(posedge sda) if (scl) act = 1'h0;
	always @(posedge scl) begin
		if (bc < 8)
			sh = {sh[6:0], sda};
		else if (rd && !first) begin
			// released ack ends the read
			if (sda) act = 1'h0;
			idx++;
		end
		bc++;
	end
	always @(negedge scl) begin
		if (bc == 8 && first) begin
			act = sh[7:1] == ADDR;
			rd = sh[0];
			idx = '0;
			sda_oe = act;
		end else if (bc == 8) begin
			if (act && !rd) mem[idx] = sh;
			if (act && !rd) idx++;
			sda_oe = act && !rd;
		end else if (bc == 9) begin
			bc = 0;
			first = 1'h0;
			sda_oe = act && rd && !mem[idx][7];
		end else if (act && rd && bc > 0)
			sda_oe = !mem[idx][3'(7 - bc)];
	end
endmodule
`default_nettype wire

// ---- verification/scm_master_tb.sv ----
// scm_master_tb: random transfers of every mode against a slave model.
// assumes the monitor binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
module scm_master_tb;
	import scm_pkg::*;
	localparam logic [6:0] SLV = 7'h2a;
	logic clock = 1'h0, rst_n = 1'h0, cmd_valid = 1'h0, tx_we = 1'h0;
	logic ce = 1'h1, hung = 1'h0;
	logic [3:0] tx_sel = '0, rx_sel = '0;
	logic [7:0] tx_byte = '0, rx_byte;
	scm_cmd_type cmd = '0;
	scm_stat_type stat;
	logic cmd_ready, scl_o, scl_oe, sda_o, sda_oe, sl_oe, scl_w, sda_w;
	logic [7:0] txm [16];
	logic [7:0] old [16];
	int miscompares = 0, cmp_count = 0, seed = 87007;
	assign scl_w = !scl_oe;
	assign sda_w = !(sda_oe || sl_oe);
	always #5 clock = ~clock;
	scm_master DUT (.clock, .rst_n, .ce, .cmd_valid, .cmd, .cmd_ready,
		.tx_we, .tx_sel, .tx_byte, .rx_sel, .rx_byte, .stat, .scl_i(scl_w),
		.scl_o, .scl_oe, .sda_i(sda_w), .sda_o, .sda_oe);
	scm_slave_model #(.ADDR(SLV)) slave (.scl(scl_w), .sda(sda_w),
		.sda_oe(sl_oe));
	function automatic logic [7:0] exp_mem(int i, int nw);
		return (i < nw) ? txm[i] : old[i];
	endfunction
	function automatic logic [3:0] rnd(int m);
		return 4'($unsigned($random(seed)) % m);
	endfunction
	task automatic check(logic [7:0] got, logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic run(scm_mode_type m, scm_rate_type r, logic [6:0] a,
		logic [3:0] la, logic [3:0] lb);
		int n, nw, nr;
		logic rdf, ok;
		ok = a == SLV;
		rdf = m inside {SCM_MODE_READ, SCM_MODE_RD_WR};
		nr = (ok && m != SCM_MODE_WRITE) ? (rdf ? la : lb) + 1 : 0;
		nw = (ok && m != SCM_MODE_READ) ? (rdf ? lb : la) + 1 : 0;
		for (int i = 0; i < 16; i++) begin
			txm[i] = 8'($random(seed));
			old[i] = 8'($random(seed));
			slave.mem[i] = old[i];
			@(posedge clock) #1;
			tx_we = 1'h1;
			tx_sel = 4'(i);
			tx_byte = txm[i];
		end
		@(posedge clock) #1;
		tx_we = 1'h0;
		cmd_valid = 1'h1;
		cmd = '{m, r, a, la, lb};
		@(posedge clock) #1;
		// busy port must refuse both strobes
		tx_we = 1'h1;
		tx_sel = '0;
		tx_byte = ~txm[0];
		@(posedge clock) #1;
		{tx_we, cmd_valid} = '0;
		for (n = 0; n < 60000 && stat.done !== 1'h1; n++) begin
			// short freeze early in the frame; state must hold
			ce = !(n >= 40 && n < 44);
			@(posedge clock) #1;
		end
		ce = 1'h1;
		if (n == 60000) begin
			miscompares++;
			hung = 1'h1;
			return;
		end
		check(stat.nack, !ok);
		for (int i = 0; i < 16; i++)
			check(slave.mem[i], exp_mem(i, nw));
		for (int i = 0; i < nr; i++) begin
			rx_sel = 4'(i);
			@(posedge clock) #1;
			check(rx_byte, exp_mem(i, rdf ? 0 : nw));
		end
		$display("test mode %0d rate %0d ended", m, r);
	endtask
	initial begin
		repeat (10) @(posedge clock);
		#1 rst_n = 1'h1;
		repeat (3) @(posedge clock);
		run(SCM_MODE_READ, SCM_RATE_100K, SLV, 4'h0, 4'h0);
		if (!hung)
			run(SCM_MODE_WRITE, SCM_RATE_1M, SLV, 4'hf, 4'h0);
		if (!hung)
			run(SCM_MODE_RD_WR, SCM_RATE_800K, SLV, rnd(6), rnd(6));
		if (!hung)
			run(SCM_MODE_WR_RD, SCM_RATE_400K, SLV, rnd(4), rnd(4));
		if (!hung)
			run(SCM_MODE_WRITE, SCM_RATE_1M, SLV ^ 7'h01, rnd(2), 4'h0);
		conclude();
	end
endmodule
`default_nettype wire
